// ### bench/ase_status_regs_monitor.sv
// ======
// Checker on the top-level ports
module ase_status_regs_monitor #(
  parameter int unsigned TMO_CYC [8] = ase_pkg::TMO_CYC_DFLT
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Status and event pins
  input wire logic PROCESSOR_BOOT_FLAG,
  input wire logic OVERCURRENT_EVENT,
  input wire logic UNDERVOLTAGE_EVENT,
  input wire logic OVERTEMPERATURE_EVENT,
  input wire logic BROWNOUT_EVENT,
  input wire logic CLOCK_LOST_EVENT,
  input wire logic SAR_DONE_EVENT,
  // Clock-error detectors
  input wire logic CLOCK_FAULT_A_EN,
  input wire logic CLOCK_FAULT_B_EN,
  input wire logic [2:0] CLOCK_FAULT_A_TIMEOUT_SEL,
  input wire logic CLOCK_A_MON,
  // Control outputs
  input wire logic DUMMY_POWERUP_FORCE_OFF,
  input wire logic TEST_CURRENT_TO_VOLTAGE_STARTUP,
  input wire logic INTEGRATOR_CLAMP_DISABLE,
  input wire logic POWER_FAULT_SIGNAL,
  input wire logic DEVICE_SHUTDOWN
);
  timeunit 1ns;
  timeprecision 1ns;

  // ======
  // Helper state
  logic [2:0] up_r;
  logic [31:0] quiet_r;
  logic mon_r;
  logic evt_any;
  logic [2:0] wlow;

  // Any fault condition pin high, and the debug field of the write data
  assign evt_any = |{OVERCURRENT_EVENT, UNDERVOLTAGE_EVENT, OVERTEMPERATURE_EVENT,
                     BROWNOUT_EVENT, CLOCK_LOST_EVENT, SAR_DONE_EVENT};
  assign wlow = REG_WDATA[2:0];

  // Cycles since reset, and cycles of detector A enabled with a quiet monitor
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      up_r <= 3'h0;
      quiet_r <= 32'h0;
      mon_r <= 1'b0;
    end else begin
      up_r <= (up_r == 3'h7) ? up_r : up_r + 3'h1;
      quiet_r <= (CLOCK_FAULT_A_EN && CLOCK_A_MON == mon_r) ? quiet_r + 32'h1 : 32'h0;
      mon_r <= CLOCK_A_MON;
    end
  end

  // ======
  // Assertions
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  a_rdata_holds: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");
  a_evt2_reserved: assert property (REG_RD && REG_ADDR == 8'h6c
    |=> REG_RDATA[7:4] == 4'h0 && REG_RDATA[1:0] == 2'h0)
    else $error("reserved event bits not zero");
  a_boot_readback: assert property ($stable(PROCESSOR_BOOT_FLAG)[*3]
    ##0 (REG_RD && REG_ADDR == 8'h65 && up_r == 3'h7)
    |=> REG_RDATA == {5'h0, $past(PROCESSOR_BOOT_FLAG), 2'h0})
    else $error("boot status readback wrong");
  a_evt_clear_read: assert property ((!evt_any)[*6] ##0 (REG_RD && REG_ADDR == 8'h68)
    ##1 (REG_RD && REG_ADDR == 8'h68 && !evt_any) |=> REG_RDATA[7:1] == 7'h00)
    else $error("event flags not cleared by read");
  a_shutdown_follows: assert property (DEVICE_SHUTDOWN == POWER_FAULT_SIGNAL)
    else $error("shutdown differs from power fault");
  a_disabled_quiet: assert property ((!CLOCK_FAULT_A_EN && !CLOCK_FAULT_B_EN)[*4]
    |-> !POWER_FAULT_SIGNAL)
    else $error("power fault with detectors disabled");
  a_fault_bounded: assert property (
    quiet_r >= TMO_CYC[CLOCK_FAULT_A_TIMEOUT_SEL] + 8 |-> POWER_FAULT_SIGNAL)
    else $error("clock timeout did not raise power fault");
  a_ctrl_write: assert property (REG_WR && REG_ADDR == 8'h35
    |=> {DUMMY_POWERUP_FORCE_OFF, TEST_CURRENT_TO_VOLTAGE_STARTUP,
         INTEGRATOR_CLAMP_DISABLE} == $past(wlow))
    else $error("debug outputs do not follow write");
  a_ctrl_hold: assert property (!(REG_WR && REG_ADDR == 8'h35)
    |=> $stable(DUMMY_POWERUP_FORCE_OFF))
    else $error("force-off changed without a write");
endmodule

bind ase_status_regs ase_status_regs_monitor #(.TMO_CYC(TMO_CYC)) u_mon (
  .MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .PROCESSOR_BOOT_FLAG(PROCESSOR_BOOT_FLAG), .OVERCURRENT_EVENT(OVERCURRENT_EVENT),
  .UNDERVOLTAGE_EVENT(UNDERVOLTAGE_EVENT), .OVERTEMPERATURE_EVENT(OVERTEMPERATURE_EVENT),
  .BROWNOUT_EVENT(BROWNOUT_EVENT), .CLOCK_LOST_EVENT(CLOCK_LOST_EVENT),
  .SAR_DONE_EVENT(SAR_DONE_EVENT), .CLOCK_FAULT_A_EN(CLOCK_FAULT_A_EN),
  .CLOCK_FAULT_B_EN(CLOCK_FAULT_B_EN), .CLOCK_FAULT_A_TIMEOUT_SEL(CLOCK_FAULT_A_TIMEOUT_SEL),
  .CLOCK_A_MON(CLOCK_A_MON), .DUMMY_POWERUP_FORCE_OFF(DUMMY_POWERUP_FORCE_OFF),
  .TEST_CURRENT_TO_VOLTAGE_STARTUP(TEST_CURRENT_TO_VOLTAGE_STARTUP),
  .INTEGRATOR_CLAMP_DISABLE(INTEGRATOR_CLAMP_DISABLE),
  .POWER_FAULT_SIGNAL(POWER_FAULT_SIGNAL), .DEVICE_SHUTDOWN(DEVICE_SHUTDOWN)
);

// ### bench/ase_status_regs_tb.sv
// ======
// Self-checking bench for the status and event bank
module ase_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [7:0] d;
  } ase_row_t;

  // Short timeouts keep the detector runs brief
  localparam int unsigned tmo_sim [8] = '{8, 16, 24, 32, 40, 48, 56, 64};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [5:0] pw = 6'h00;
  logic boot = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [1:0] en = 2'h0;
  logic [2:0] sel_a = 3'h0;
  logic [1:0] mon = 2'h0;
  logic [2:0] ctl;
  logic lpe;
  logic pfault;
  logic sdown;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int evpos [6] = '{7, 6, 4, 3, 2, 1};
  logic [7:0] d1;
  logic [7:0] d2;
  // Write rows carry data, read rows carry the expected value
  ase_row_t rows [21] = '{
    '{1'b0, 8'h35, 8'h00}, '{1'b0, 8'h79, 8'h00}, '{1'b0, 8'h64, 8'h00},
    '{1'b0, 8'h65, 8'h00}, '{1'b0, 8'h68, 8'h00}, '{1'b0, 8'h6c, 8'h00},
    '{1'b1, 8'h35, 8'ha5}, '{1'b0, 8'h35, 8'ha5}, '{1'b1, 8'h79, 8'h80},
    '{1'b0, 8'h79, 8'h80}, '{1'b1, 8'h64, 8'hff}, '{1'b0, 8'h64, 8'h03},
    '{1'b1, 8'h65, 8'hff}, '{1'b0, 8'h65, 8'h00}, '{1'b1, 8'h68, 8'hff},
    '{1'b0, 8'h68, 8'h01}, '{1'b0, 8'h68, 8'h01}, '{1'b1, 8'h6c, 8'hff},
    '{1'b0, 8'h6c, 8'h00}, '{1'b1, 8'h12, 8'hff}, '{1'b0, 8'h12, 8'h00}};

  // ======
  // Design under test
  ase_status_regs #(.TMO_CYC(tmo_sim)) uut (
    .MCLK(mclk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .CONVERTER_POWERED_FLAG(pw[5]), .OUTPUT_STAGE_POWERED_FLAG(pw[4]),
    .BOOST_POWERED_FLAG(pw[3]), .BOOST_BYPASS_ACTIVE_FLAG(pw[2]),
    .CURRENT_SENSE_POWERED_FLAG(pw[1]), .VOLTAGE_SENSE_POWERED_FLAG(pw[0]),
    .PROCESSOR_BOOT_FLAG(boot), .OVERCURRENT_EVENT(ev[0]), .UNDERVOLTAGE_EVENT(ev[1]),
    .OVERTEMPERATURE_EVENT(ev[2]), .BROWNOUT_EVENT(ev[3]), .CLOCK_LOST_EVENT(ev[4]),
    .SAR_DONE_EVENT(ev[5]), .CLOCK_FAULT_A_EN(en[0]), .CLOCK_FAULT_B_EN(en[1]),
    .CLOCK_FAULT_A_TIMEOUT_SEL(sel_a), .CLOCK_FAULT_B_TIMEOUT_SEL(sel_a),
    .CLOCK_A_MON(mon[0]), .CLOCK_B_MON(mon[1]), .DUMMY_POWERUP_FORCE_OFF(ctl[2]),
    .TEST_CURRENT_TO_VOLTAGE_STARTUP(ctl[1]), .INTEGRATOR_CLAMP_DISABLE(ctl[0]),
    .LOW_POWER_EN(lpe), .POWER_FAULT_SIGNAL(pfault), .DEVICE_SHUTDOWN(sdown)
  );

  // Clock and cycle ceiling
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end

  // ======
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  // One read, or two back to back with the strobe held
  task automatic rd_reg(input logic [7:0] a, input int n, output logic [7:0] q1,
                        output logic [7:0] q2);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    if (n == 1) reg_rd <= 1'b0;
    #1 q1 = reg_rdata;
    q2 = q1;
    if (n == 2) begin
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 q2 = reg_rdata;
    end
    @(posedge mclk);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ======
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({5'h0, ctl}, 8'h00);
    foreach (rows[i]) begin
      if (rows[i].wr) wr_reg(rows[i].a, rows[i].d);
      else begin
        rd_reg(rows[i].a, 1, d1, d2);
        chk(d1, rows[i].d);
      end
    end
    chk({4'h0, lpe, ctl}, 8'h0d);
    wr_reg(8'h35, 8'h02);
    chk({5'h0, ctl}, 8'h02);
    wr_reg(8'h64, 8'h00);
    // Power-state pins one at a time
    for (int i = 0; i < 6; i++) begin
      pw <= 6'h01 << i;
      repeat (4) @(posedge mclk);
      rd_reg(8'h64, 1, d1, d2);
      chk(d1, {6'h01 << i, 2'h0});
    end
    pw <= 6'h00;
    // Boot in progress, then complete
    for (int i = 0; i < 2; i++) begin
      boot <= (i == 0);
      repeat (4) @(posedge mclk);
      rd_reg(8'h65, 1, d1, d2);
      chk(d1, (i == 0) ? 8'h04 : 8'h00);
    end
    // One-cycle condition pulses, flag stays until read
    for (int i = 0; i < 6; i++) begin
      ev <= 6'h01 << i;
      @(posedge mclk);
      ev <= 6'h00;
      repeat (8) @(posedge mclk);
      rd_reg(8'h68, 2, d1, d2);
      chk(d1, 8'h01 | (8'h01 << evpos[i]));
      chk(d2, 8'h01);
    end
    // Condition present across the clearing read
    ev <= 6'h01;
    repeat (6) @(posedge mclk);
    rd_reg(8'h68, 2, d1, d2);
    chk(d2, 8'h81);
    ev <= 6'h00;
    repeat (6) @(posedge mclk);
    rd_reg(8'h68, 2, d1, d2);
    chk(d2, 8'h01);
    // Detector A at every timeout code
    for (int s = 0; s < 8; s++) begin
      sel_a <= s[2:0];
      en <= 2'b01;
      repeat (tmo_sim[s] - 1) @(posedge mclk);
      #1 chk({6'h0, pfault, sdown}, 8'h00);
      repeat (10) @(posedge mclk);
      #1 chk({6'h0, pfault, sdown}, 8'h03);
      @(posedge mclk);
      en <= 2'b00;
      repeat (4) @(posedge mclk);
      rd_reg(8'h6c, 2, d1, d2);
      chk(d1, 8'h08);
      chk(d2, 8'h00);
    end
    // Detector B at the shortest code
    sel_a <= 3'h0;
    en <= 2'b10;
    repeat (20) @(posedge mclk);
    #1 chk({7'h0, pfault}, 8'h01);
    @(posedge mclk);
    en <= 2'b00;
    repeat (4) @(posedge mclk);
    rd_reg(8'h6c, 2, d1, d2);
    chk(d1, 8'h04);
    chk(d2, 8'h00);
    // Monitored clock active within the timeout: no fault
    en <= 2'b01;
    sel_a <= 3'h0;
    for (int i = 0; i < 12; i++) begin
      repeat (4) @(posedge mclk);
      mon[0] <= ~mon[0];
    end
    #1 chk({7'h0, pfault}, 8'h00);
    // Mid-run reset clears flags and written fields
    @(posedge mclk);
    en <= 2'h0;
    ev <= 6'h01;
    repeat (4) @(posedge mclk);
    rst <= 1'b1;
    ev <= 6'h00;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({4'h0, lpe, ctl}, 8'h00);
    rd_reg(8'h68, 1, d1, d2);
    chk(d1, 8'h00);
    summarize();
  end
endmodule

// ### rtl/ase_clkerr_det.sv
// ==========================================================
// Clock-error detector: times the gap between monitored edges
module ase_clkerr_det #(
  parameter int unsigned TMO_CYC [8] = ase_pkg::TMO_CYC_DFLT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic en,
  input wire logic [2:0] sel,
  input wire logic clk_edge,
  // Status
  output logic fault_pulse,
  output logic fault_lvl
);

  typedef enum logic [1:0] {DET_IDLE, DET_WATCH, DET_FAULT} ase_det_st_t;

  ase_det_st_t st_r;
  ase_det_st_t st_nxt;
  logic [ase_pkg::TMO_CNT_W-1:0] cnt_r;
  logic [ase_pkg::TMO_CNT_W-1:0] cnt_nxt;
  logic [ase_pkg::TMO_CNT_W-1:0] limit;
  logic pulse_r;
  logic pulse_nxt;

  // Selected timeout in cycles
  assign limit = ase_pkg::TMO_CNT_W'(TMO_CYC[sel]);

  // Next state: count idle cycles, fault once the gap reaches the limit
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    pulse_nxt = 1'b0;
    case (st_r)
      DET_IDLE: begin
        cnt_nxt = '0;
        if (en) begin
          st_nxt = DET_WATCH;
        end
      end
      DET_WATCH: begin
        if (!en) begin
          st_nxt = DET_IDLE;
        end else if (clk_edge) begin
          cnt_nxt = '0;
        end else if (cnt_r >= limit - 1'b1) begin
          st_nxt = DET_FAULT;
          pulse_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      DET_FAULT: begin
        cnt_nxt = '0;
        if (!en) begin
          st_nxt = DET_IDLE;
        end else if (clk_edge) begin
          st_nxt = DET_WATCH; // Clock back, recover
        end
      end
      default: begin
        st_nxt = DET_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= DET_IDLE;
      cnt_r <= '0;
      pulse_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign fault_pulse = pulse_r;
  assign fault_lvl = (st_r == DET_FAULT);

endmodule

// ### rtl/ase_evt_if.sv
// ==========================================================
// Event bank carrier: conditions and clear in, sticky flags out
interface ase_evt_if #(parameter int W = 8);
  logic [W-1:0] cond;
  logic clr;
  logic [W-1:0] flags;

  modport latch (input cond, input clr, output flags);
  modport owner (output cond, output clr, input flags);
endinterface

// ### rtl/ase_evt_latch.sv
// ==========================================================
// Sticky event flags, cleared as a bank, set beats clear
module ase_evt_latch #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Event bank
  ase_evt_if.latch ev
);

  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  // Next flags: hold, clear on read, then OR in new events
  always_comb begin
    flags_nxt = ev.clr ? '0 : flags_r; // Hold until read
    flags_nxt = flags_nxt | ev.cond; // New event beats the clear
  end

  // Flag register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign ev.flags = flags_r;

endmodule

// ### rtl/ase_pkg.sv
// ==========================================================
// Shared constants for the amplifier status and event bank
package ase_pkg;

  // ========================================================
  // Register offsets
  localparam logic [7:0] OFF_TEST_OVERRIDE_CTRL = 8'h35;
  localparam logic [7:0] OFF_BLOCK_POWER_STATE = 8'h64;
  localparam logic [7:0] OFF_DSP_BOOT_STATE = 8'h65;
  localparam logic [7:0] OFF_FAULT_EVENT_LATCH = 8'h68;
  localparam logic [7:0] OFF_CLOCK_FAULT_EVENT_LATCH = 8'h6c;
  localparam logic [7:0] OFF_SLEEP_SHUTDOWN_CTRL = 8'h79;

  // ========================================================
  // Reset values, and the read data of unmapped offsets
  localparam logic [7:0] RST_TEST_OVERRIDE_CTRL = 8'h00;
  localparam logic [7:0] RST_SLEEP_SHUTDOWN_CTRL = 8'h00;
  localparam logic [1:0] RST_POWER_STATE_SPARE = 2'h0;
  localparam logic RST_FAULT_SPARE = 1'b0;
  localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ========================================================
  // Field positions
  localparam int POS_DUMMY_POWERUP_FORCE_OFF = 2;
  localparam int POS_TEST_I2V_STARTUP = 1;
  localparam int POS_INTEGRATOR_CLAMP_DISABLE = 0;
  localparam int POS_CONVERTER_POWERED = 7;
  localparam int POS_OUTPUT_STAGE_POWERED = 6;
  localparam int POS_BOOST_POWERED = 5;
  localparam int POS_BOOST_BYPASS_ACTIVE = 4;
  localparam int POS_CURRENT_SENSE_POWERED = 3;
  localparam int POS_VOLTAGE_SENSE_POWERED = 2;
  localparam int POS_PROCESSOR_BOOT = 2;
  localparam int POS_OVERCURRENT = 7;
  localparam int POS_UNDERVOLTAGE = 6;
  localparam int POS_OVERTEMPERATURE = 4;
  localparam int POS_BROWNOUT = 3;
  localparam int POS_CLOCK_LOST = 2;
  localparam int POS_SAR_DONE = 1;
  localparam int POS_FAULT_SPARE = 0;
  localparam int POS_CLOCK_FAULT_A = 3;
  localparam int POS_CLOCK_FAULT_B = 2;
  localparam int POS_LOW_POWER_EN = 7;

  // ========================================================
  // Clock and clock-error timeouts
  localparam int unsigned CLK_FREQ_KHZ = 25000;
  localparam int TMO_CNT_W = 26;
  localparam int unsigned TMO_US [8] = '{2730, 22000, 44000, 87000,
                                         174000, 350000, 700000, 1400000};
  // Cycles per microsecond first, so the longest timeout stays inside 32 bits
  localparam int unsigned TMO_CYC_DFLT [8] = '{
    TMO_US[0] * (CLK_FREQ_KHZ / 1000), TMO_US[1] * (CLK_FREQ_KHZ / 1000),
    TMO_US[2] * (CLK_FREQ_KHZ / 1000), TMO_US[3] * (CLK_FREQ_KHZ / 1000),
    TMO_US[4] * (CLK_FREQ_KHZ / 1000), TMO_US[5] * (CLK_FREQ_KHZ / 1000),
    TMO_US[6] * (CLK_FREQ_KHZ / 1000), TMO_US[7] * (CLK_FREQ_KHZ / 1000)};

endpackage

// ### rtl/ase_status_regs.sv
// Overview of operation
// - Power-state bits show DAC, output, boost, sense ADCs.
// - Boot-status bit 2 shows DSP boot progress.
// - Event flags stay set after condition ends.
// - Reading an event register clears its flags.
// - Flag set if event since last read.
// - First event bit 7 flags over-current.
// - First event bit 6 flags under-voltage.
// - First event bit 4 flags over-temperature.
// - First event bit 3 flags brownout.
// - First event bit 2 flags clock lost.
// - First event bit 1 flags SAR complete.
// - Second event bits 3, 2 flag clock errors.
// - Debug bit 2 forces dummy power-up down.
// - Clock timeout shuts down, raises power fault.
module ase_status_regs #(
  parameter int unsigned TMO_CYC [8] = ase_pkg::TMO_CYC_DFLT
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Block power state and boot status pins
  input wire logic CONVERTER_POWERED_FLAG,
  input wire logic OUTPUT_STAGE_POWERED_FLAG,
  input wire logic BOOST_POWERED_FLAG,
  input wire logic BOOST_BYPASS_ACTIVE_FLAG,
  input wire logic CURRENT_SENSE_POWERED_FLAG,
  input wire logic VOLTAGE_SENSE_POWERED_FLAG,
  input wire logic PROCESSOR_BOOT_FLAG,
  // Fault condition pins
  input wire logic OVERCURRENT_EVENT,
  input wire logic UNDERVOLTAGE_EVENT,
  input wire logic OVERTEMPERATURE_EVENT,
  input wire logic BROWNOUT_EVENT,
  input wire logic CLOCK_LOST_EVENT,
  input wire logic SAR_DONE_EVENT,
  // Clock-error detector setup and monitored clocks
  input wire logic CLOCK_FAULT_A_EN,
  input wire logic CLOCK_FAULT_B_EN,
  input wire logic [2:0] CLOCK_FAULT_A_TIMEOUT_SEL,
  input wire logic [2:0] CLOCK_FAULT_B_TIMEOUT_SEL,
  input wire logic CLOCK_A_MON,
  input wire logic CLOCK_B_MON,
  // Control outputs
  output logic DUMMY_POWERUP_FORCE_OFF,
  output logic TEST_CURRENT_TO_VOLTAGE_STARTUP,
  output logic INTEGRATOR_CLAMP_DISABLE,
  output logic LOW_POWER_EN,
  output logic POWER_FAULT_SIGNAL,
  output logic DEVICE_SHUTDOWN
);

  // ==========================================================
  // Address decode helper
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
    addr_hit = (addr == off);
  endfunction

  // ==========================================================
  // Pin synchronisers
  localparam int NSYNC = 15;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  // Gather asynchronous pins into one vector
  assign pin_raw = {CONVERTER_POWERED_FLAG, OUTPUT_STAGE_POWERED_FLAG,
                    BOOST_POWERED_FLAG, BOOST_BYPASS_ACTIVE_FLAG,
                    CURRENT_SENSE_POWERED_FLAG, VOLTAGE_SENSE_POWERED_FLAG,
                    PROCESSOR_BOOT_FLAG, OVERCURRENT_EVENT, UNDERVOLTAGE_EVENT,
                    OVERTEMPERATURE_EVENT, BROWNOUT_EVENT, CLOCK_LOST_EVENT,
                    SAR_DONE_EVENT, CLOCK_A_MON, CLOCK_B_MON};

  // Two flip-flops per pin; only the second stage is read
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // Named views of the synchronised pins
  logic converter_powered_flag;
  logic output_stage_powered_flag;
  logic boost_powered_flag;
  logic boost_bypass_active_flag;
  logic current_sense_powered_flag;
  logic voltage_sense_powered_flag;
  logic processor_boot_flag;
  logic overcurrent_event;
  logic undervoltage_event;
  logic overtemperature_event;
  logic brownout_event;
  logic clock_lost_event;
  logic sar_done_event;
  logic [1:0] mon_s;

  assign {converter_powered_flag, output_stage_powered_flag, boost_powered_flag,
          boost_bypass_active_flag, current_sense_powered_flag,
          voltage_sense_powered_flag, processor_boot_flag, overcurrent_event,
          undervoltage_event, overtemperature_event, brownout_event,
          clock_lost_event, sar_done_event, mon_s} = sync2_r;

  // ==========================================================
  // Register port decode
  logic wr_test;
  logic wr_power;
  logic wr_fault;
  logic wr_sleep;
  logic rd_fault;
  logic rd_clock_fault;

  // Write and clearing-read strobes
  assign wr_test = REG_WR && addr_hit(REG_ADDR, ase_pkg::OFF_TEST_OVERRIDE_CTRL);
  assign wr_power = REG_WR && addr_hit(REG_ADDR, ase_pkg::OFF_BLOCK_POWER_STATE);
  assign wr_fault = REG_WR && addr_hit(REG_ADDR, ase_pkg::OFF_FAULT_EVENT_LATCH);
  assign wr_sleep = REG_WR && addr_hit(REG_ADDR, ase_pkg::OFF_SLEEP_SHUTDOWN_CTRL);
  assign rd_fault = REG_RD && addr_hit(REG_ADDR, ase_pkg::OFF_FAULT_EVENT_LATCH);
  assign rd_clock_fault = REG_RD
                          && addr_hit(REG_ADDR, ase_pkg::OFF_CLOCK_FAULT_EVENT_LATCH);

  // ==========================================================
  // Writable storage
  logic [7:0] test_ctrl_r;
  logic [7:0] test_ctrl_nxt;
  logic [7:0] sleep_ctrl_r;
  logic [7:0] sleep_ctrl_nxt;
  logic [1:0] power_spare_r;
  logic [1:0] power_spare_nxt;
  logic fault_spare_r;
  logic fault_spare_nxt;

  // Next values of the read/write fields
  always_comb begin
    test_ctrl_nxt = test_ctrl_r;
    sleep_ctrl_nxt = sleep_ctrl_r;
    power_spare_nxt = power_spare_r;
    fault_spare_nxt = fault_spare_r;
    if (wr_test) begin
      test_ctrl_nxt = REG_WDATA;
    end
    if (wr_sleep) begin
      sleep_ctrl_nxt = REG_WDATA;
    end
    if (wr_power) begin
      power_spare_nxt = REG_WDATA[1:0]; // Status bits above ignore writes
    end
    if (wr_fault) begin
      fault_spare_nxt = REG_WDATA[ase_pkg::POS_FAULT_SPARE];
    end
  end

  // Register the writable fields
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      test_ctrl_r <= ase_pkg::RST_TEST_OVERRIDE_CTRL;
      sleep_ctrl_r <= ase_pkg::RST_SLEEP_SHUTDOWN_CTRL;
      power_spare_r <= ase_pkg::RST_POWER_STATE_SPARE;
      fault_spare_r <= ase_pkg::RST_FAULT_SPARE;
    end else begin
      test_ctrl_r <= test_ctrl_nxt;
      sleep_ctrl_r <= sleep_ctrl_nxt;
      power_spare_r <= power_spare_nxt;
      fault_spare_r <= fault_spare_nxt;
    end
  end

  // Control outputs straight from register bits
  assign DUMMY_POWERUP_FORCE_OFF = test_ctrl_r[ase_pkg::POS_DUMMY_POWERUP_FORCE_OFF];
  assign TEST_CURRENT_TO_VOLTAGE_STARTUP = test_ctrl_r[ase_pkg::POS_TEST_I2V_STARTUP];
  assign INTEGRATOR_CLAMP_DISABLE = test_ctrl_r[ase_pkg::POS_INTEGRATOR_CLAMP_DISABLE];
  assign LOW_POWER_EN = sleep_ctrl_r[ase_pkg::POS_LOW_POWER_EN];

  // ==========================================================
  // Clock-error detectors
  logic [1:0] mon_q_r;
  logic [1:0] mon_q_nxt;
  logic [1:0] mon_edge;
  logic [1:0] det_en;
  logic [2:0] det_sel [2];
  logic [1:0] det_pulse;
  logic [1:0] det_lvl;

  // Previous monitored level for edge detection
  always_comb begin
    mon_q_nxt = mon_s;
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mon_q_r <= 2'h0;
    end else begin
      mon_q_r <= mon_q_nxt;
    end
  end

  // Any change of the monitored clock counts as activity
  assign mon_edge = mon_s ^ mon_q_r;
  assign det_en = {CLOCK_FAULT_A_EN, CLOCK_FAULT_B_EN};
  assign det_sel[1] = CLOCK_FAULT_A_TIMEOUT_SEL;
  assign det_sel[0] = CLOCK_FAULT_B_TIMEOUT_SEL;

  // Detector A at index 1, detector B at index 0
  generate
    for (gi = 0; gi < 2; gi++) begin : g_det
      ase_clkerr_det #(
        .TMO_CYC(TMO_CYC)
      ) u_det (
        .clk(MCLK),
        .rst(RST),
        .en(det_en[gi]),
        .sel(det_sel[gi]),
        .clk_edge(mon_edge[gi]),
        .fault_pulse(det_pulse[gi]),
        .fault_lvl(det_lvl[gi])
      );
    end
  endgenerate

  // Power fault and shutdown follow any timed-out detector
  logic pfault_r;
  logic pfault_nxt;

  always_comb begin
    pfault_nxt = |det_lvl;
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pfault_r <= 1'b0;
    end else begin
      pfault_r <= pfault_nxt;
    end
  end

  assign POWER_FAULT_SIGNAL = pfault_r;
  assign DEVICE_SHUTDOWN = pfault_r;

  // ==========================================================
  // Sticky event banks
  ase_evt_if #(.W(8)) fault_ev ();
  ase_evt_if #(.W(8)) clock_fault_ev ();

  // Fault conditions placed at their bit positions
  always_comb begin
    fault_ev.cond = 8'h00;
    fault_ev.cond[ase_pkg::POS_OVERCURRENT] = overcurrent_event;
    fault_ev.cond[ase_pkg::POS_UNDERVOLTAGE] = undervoltage_event;
    fault_ev.cond[ase_pkg::POS_OVERTEMPERATURE] = overtemperature_event;
    fault_ev.cond[ase_pkg::POS_BROWNOUT] = brownout_event;
    fault_ev.cond[ase_pkg::POS_CLOCK_LOST] = clock_lost_event;
    fault_ev.cond[ase_pkg::POS_SAR_DONE] = sar_done_event;
    clock_fault_ev.cond = 8'h00;
    clock_fault_ev.cond[ase_pkg::POS_CLOCK_FAULT_A] = det_pulse[1];
    clock_fault_ev.cond[ase_pkg::POS_CLOCK_FAULT_B] = det_pulse[0];
  end

  // A read of a bank clears it in the same edge that returns it
  assign fault_ev.clr = rd_fault;
  assign clock_fault_ev.clr = rd_clock_fault;

  // Flags hold until read; new events win over the clear
  ase_evt_latch #(
    .W(8)
  ) u_fault_latch (
    .clk(MCLK),
    .rst(RST),
    .ev(fault_ev.latch)
  );

  ase_evt_latch #(
    .W(8)
  ) u_clock_fault_latch (
    .clk(MCLK),
    .rst(RST),
    .ev(clock_fault_ev.latch)
  );

  // ==========================================================
  // Read data
  logic [7:0] power_view;
  logic [7:0] boot_view;
  logic [7:0] fault_view;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Live power state, spare bits from storage
  always_comb begin
    power_view = {6'h00, power_spare_r};
    power_view[ase_pkg::POS_CONVERTER_POWERED] = converter_powered_flag;
    power_view[ase_pkg::POS_OUTPUT_STAGE_POWERED] = output_stage_powered_flag;
    power_view[ase_pkg::POS_BOOST_POWERED] = boost_powered_flag;
    power_view[ase_pkg::POS_BOOST_BYPASS_ACTIVE] = boost_bypass_active_flag;
    power_view[ase_pkg::POS_CURRENT_SENSE_POWERED] = current_sense_powered_flag;
    power_view[ase_pkg::POS_VOLTAGE_SENSE_POWERED] = voltage_sense_powered_flag;
    boot_view = 8'h00;
    boot_view[ase_pkg::POS_PROCESSOR_BOOT] = processor_boot_flag; // High while busy
    fault_view = fault_ev.flags;
    fault_view[ase_pkg::POS_FAULT_SPARE] = fault_spare_r;
  end

  // Read multiplexer, held until the next read
  always_comb begin
    rdata_nxt = rdata_r;
    if (REG_RD) begin
      case (REG_ADDR)
        ase_pkg::OFF_TEST_OVERRIDE_CTRL: rdata_nxt = test_ctrl_r;
        ase_pkg::OFF_BLOCK_POWER_STATE: rdata_nxt = power_view;
        ase_pkg::OFF_DSP_BOOT_STATE: rdata_nxt = boot_view;
        ase_pkg::OFF_FAULT_EVENT_LATCH: rdata_nxt = fault_view;
        ase_pkg::OFF_CLOCK_FAULT_EVENT_LATCH: rdata_nxt = clock_fault_ev.flags;
        ase_pkg::OFF_SLEEP_SHUTDOWN_CTRL: rdata_nxt = sleep_ctrl_r;
        default: rdata_nxt = ase_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA = rdata_r;

endmodule
